// ===== hdl/clk_divider.sv
// Power-of-two clock divider with a square-wave output
`timescale 1ns/1ps
module clk_divider #(
    parameter int CNT_W = 16
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic tick,
    input wire logic [3:0] div_log2,
    output logic div_out
);
    if (CNT_W < 16) begin : g_bad_width
        $error("clk_divider needs CNT_W of at least 16");
    end

    logic [CNT_W-1:0] cnt_ff;
    logic out_ff;
    logic [CNT_W-1:0] half_mask;
    logic half_done;

    assign half_mask = (CNT_W'(1) << div_log2) - CNT_W'(1);
    assign half_done = (cnt_ff & half_mask) == half_mask;
    assign div_out = out_ff;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_ff <= '0;
            out_ff <= 1'b0;
        end else if (clk_en && tick) begin
            // Toggle each half period; div_log2 of 0 toggles on every tick, halving the tick rate
            if (div_log2 == 4'h0 || half_done) begin
                cnt_ff <= '0;
                out_ff <= ~out_ff;
            end else begin
                cnt_ff <= cnt_ff + CNT_W'(1);
            end
        end
    end
endmodule

// ===== hdl/prbs_gen_pkg.sv
// Shared constants and types for the test pattern source
package prbs_gen_pkg;

    // ------------------------------------------------------------
    // Pattern, sequence and sync selections; burst states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PAT_PRBS = 2'b00,
        PAT_HALF = 2'b01,
        PAT_SIXTEENTH = 2'b10
    } pattern_sel_t;

    typedef enum logic [2:0] {
        SEQ_7 = 3'b000,
        SEQ_9 = 3'b001,
        SEQ_15 = 3'b010,
        SEQ_23 = 3'b011,
        SEQ_31 = 3'b100
    } seq_sel_t;

    typedef enum logic [1:0] {
        SYNC_DIVIDED = 2'b00,
        SYNC_MARKER = 2'b01
    } sync_mode_t;

    typedef enum logic [1:0] {
        BURST_IDLE = 2'b00,
        BURST_RUN = 2'b01
    } burst_state_t;

    // ------------------------------------------------------------
    // Configuration carrier
    // ------------------------------------------------------------
    typedef struct packed {
        pattern_sel_t pattern;
        seq_sel_t seq;
        logic negative_polarity;
        sync_mode_t sync_mode;
        logic sync_src_forwarded;
        logic [3:0] sync_div_log2;
        logic high_band;
        logic channel_pair_high;
        logic scope_tracking;
    } pattern_cfg_t;

    // ------------------------------------------------------------
    // Numbers
    // ------------------------------------------------------------
    localparam int LFSR_W = 31;
    localparam logic [30:0] SEED = 31'h0000_0001;
    localparam int TAP_7_A = 6;
    localparam int TAP_7_B = 7;
    localparam int TAP_9_A = 5;
    localparam int TAP_9_B = 9;
    localparam int TAP_15_A = 14;
    localparam int TAP_15_B = 15;
    localparam int TAP_23_A = 18;
    localparam int TAP_23_B = 23;
    localparam int TAP_31_A = 28;
    localparam int TAP_31_B = 31;
    localparam logic [4:0] BURST_HIGH_BAND = 5'h14;
    localparam logic [4:0] BURST_LOW_BAND = 5'h08;
    localparam int SIXTEENTH_HALF = 8;
    localparam int FWD_DIV_HIGH_BAND = 4;
    localparam int FWD_DIV_LOW_BAND = 2;
    localparam int CLK_PERIOD_NS = 10;
    localparam longint INDICATOR_TIME_NS = 64'd1000000000;
    localparam int INDICATOR_CYCLES = int'(INDICATOR_TIME_NS / CLK_PERIOD_NS);
    localparam logic [30:0] RESET_LFSR = 31'h0000_0000;

endpackage

// ===== hdl/prbs_lfsr.sv
// Selectable-length Fibonacci PRBS shift register
`timescale 1ns/1ps
module prbs_lfsr #(
    parameter int WIDTH = 31
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic reseed,
    input wire prbs_gen_pkg::seq_sel_t seq,
    output logic bit_out,
    output logic wrap
);
    if (WIDTH != prbs_gen_pkg::LFSR_W) begin : g_bad_width
        $error("prbs_lfsr needs WIDTH 31");
    end

    logic [WIDTH-1:0] lfsr_ff;
    logic [WIDTH-1:0] nxt_lfsr;
    logic fb_bit;
    logic [4:0] len;
    logic at_seed;
    logic [WIDTH-1:0] len_mask;
    logic stuck;

    // ------------------------------------------------------------
    // Tap selection
    // ------------------------------------------------------------
    // Stage k is bit k-1; stage 1 takes feedback
    assign fb_bit =
        (seq == prbs_gen_pkg::SEQ_7) ?
            lfsr_ff[prbs_gen_pkg::TAP_7_A-1] ^ lfsr_ff[prbs_gen_pkg::TAP_7_B-1] : // see RL1
        (seq == prbs_gen_pkg::SEQ_9) ?
            lfsr_ff[prbs_gen_pkg::TAP_9_A-1] ^ lfsr_ff[prbs_gen_pkg::TAP_9_B-1] : // see RL4
        (seq == prbs_gen_pkg::SEQ_15) ?
            lfsr_ff[prbs_gen_pkg::TAP_15_A-1] ^ lfsr_ff[prbs_gen_pkg::TAP_15_B-1] :
        (seq == prbs_gen_pkg::SEQ_23) ?
            lfsr_ff[prbs_gen_pkg::TAP_23_A-1] ^ lfsr_ff[prbs_gen_pkg::TAP_23_B-1] :
            lfsr_ff[prbs_gen_pkg::TAP_31_A-1] ^ lfsr_ff[prbs_gen_pkg::TAP_31_B-1];

    assign len = (seq == prbs_gen_pkg::SEQ_7) ? 5'h07 :
                 (seq == prbs_gen_pkg::SEQ_9) ? 5'h09 :
                 (seq == prbs_gen_pkg::SEQ_15) ? 5'h0f :
                 (seq == prbs_gen_pkg::SEQ_23) ? 5'h17 : 5'h1f;

    assign nxt_lfsr = {lfsr_ff[WIDTH-2:0], fb_bit};
    assign len_mask = (WIDTH'(1) << len) - WIDTH'(1);
    // Maximal taps revisit the seed once per 2^n-1 shifts; bits above n are ignored
    assign at_seed = ((lfsr_ff & len_mask) == prbs_gen_pkg::SEED);
    // A length change can leave the active stages all zero, which would lock up
    assign stuck = ((lfsr_ff & len_mask) == prbs_gen_pkg::RESET_LFSR); // see RL2
    assign wrap = at_seed; // see RL3
    assign bit_out = lfsr_ff[len - 5'h01];

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Reset holds zero only until the first enabled edge reseeds
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            lfsr_ff <= prbs_gen_pkg::RESET_LFSR;
        end else if (clk_en) begin
            if (reseed || stuck) begin
                lfsr_ff <= prbs_gen_pkg::SEED; // see RL2
            end else begin
                lfsr_ff <= nxt_lfsr; // see RL5, RL6
            end
        end
    end
endmodule

// ===== hdl/pulse_pattern_source.sv
// Test pattern source: PRBS and clock patterns, sync, forwarded clock, error bursts
//
// Operation
// RL1: 127-bit sequence feeds back stages six xor seven
// RL2: Seed holds a one before shifting starts
// RL3: Seven-stage sequence repeats every 127 bits
// RL4: Lengths 7,9,15,23,31 with their listed taps
// RL5: Longest runs: n ones, n-1 zeros
// RL6: Ones fill half of each period
// RL7: Choose PRBS, half-rate or sixteenth-rate clock
// RL8: Half-rate pattern alternates one and zero
// RL9: Sixteenth-rate pattern: eight ones, eight zeros
// RL10: Polarity selects positive or negative logic output
// RL11: Sync output clock is synchronous with data
// RL12: Marker mode pulses once per pattern repetition
// RL13: Forwarded clock quarter or half by band
// RL14: Forwarded clock source picks channel pair
// RL15: Error command inverts 20 or 8 bits
// RL16: Injection raises an error-injected indicator
// RL17: Marker sync refused while scope tracks rate
// RL18: Indicator holds one second, then clears
// RL19: Sync selects source and division ratio
// RL20: Complement output always inverts true output
`timescale 1ns/1ps
module pulse_pattern_source #(
    parameter int INDICATOR_CYCLES = prbs_gen_pkg::INDICATOR_CYCLES,
    parameter int BURST_W = 5
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire prbs_gen_pkg::pattern_cfg_t cfg,
    input wire logic reseed,
    input wire logic insert_error,
    input wire logic fwd_clk_pair_low,
    input wire logic fwd_clk_pair_high,
    output logic data_out,
    output logic data_out_n,
    output logic sync_out,
    output logic fwd_clk_out,
    output logic error_injected,
    output logic marker_refused
);
    if (INDICATOR_CYCLES < 1) begin : g_bad_indicator
        $error("INDICATOR_CYCLES must be at least 1");
    end
    if (BURST_W < 5) begin : g_bad_burst
        $error("BURST_W must hold a burst of 20");
    end

    // ------------------------------------------------------------
    // PRBS core
    // ------------------------------------------------------------
    logic prbs_bit;
    logic prbs_wrap;

    prbs_lfsr #(
        .WIDTH(prbs_gen_pkg::LFSR_W)
    ) u_lfsr (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .reseed(reseed),
        .seq(cfg.seq),
        .bit_out(prbs_bit),
        .wrap(prbs_wrap)
    );

    // ------------------------------------------------------------
    // Clock patterns
    // ------------------------------------------------------------
    logic [3:0] phase_ff;
    logic half_bit;
    logic sixteenth_bit;
    logic raw_bit;

    assign half_bit = ~phase_ff[0]; // see RL8
    // Phase 0..7 ones, 8..15 zeros
    assign sixteenth_bit = (phase_ff < 4'(prbs_gen_pkg::SIXTEENTH_HALF)); // see RL9

    always_comb begin
        case (cfg.pattern) // see RL7
            prbs_gen_pkg::PAT_PRBS: raw_bit = prbs_bit;
            prbs_gen_pkg::PAT_HALF: raw_bit = half_bit;
            prbs_gen_pkg::PAT_SIXTEENTH: raw_bit = sixteenth_bit;
            default: raw_bit = prbs_bit;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_ff <= 4'h0;
        end else if (clk_en) begin
            phase_ff <= phase_ff + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Error burst
    // ------------------------------------------------------------
    prbs_gen_pkg::burst_state_t burst_state_ff;
    prbs_gen_pkg::burst_state_t nxt_burst_state;
    logic [BURST_W-1:0] burst_cnt_ff;
    logic [BURST_W-1:0] nxt_burst_cnt;
    logic [BURST_W-1:0] burst_len;
    logic burst_start;
    logic flip;

    assign burst_len = cfg.high_band ?
        BURST_W'(prbs_gen_pkg::BURST_HIGH_BAND) :
        BURST_W'(prbs_gen_pkg::BURST_LOW_BAND); // see RL15
    // A command during a burst is ignored, so bursts never merge
    assign burst_start = insert_error && (burst_state_ff == prbs_gen_pkg::BURST_IDLE);
    assign flip = (burst_state_ff == prbs_gen_pkg::BURST_RUN); // see RL15

    always_comb begin
        nxt_burst_state = burst_state_ff;
        nxt_burst_cnt = burst_cnt_ff;
        case (burst_state_ff)
            prbs_gen_pkg::BURST_IDLE: begin
                if (burst_start) begin
                    nxt_burst_state = prbs_gen_pkg::BURST_RUN;
                    nxt_burst_cnt = burst_len - BURST_W'(1);
                end
            end
            prbs_gen_pkg::BURST_RUN: begin
                if (burst_cnt_ff == '0) begin
                    nxt_burst_state = prbs_gen_pkg::BURST_IDLE;
                end else begin
                    nxt_burst_cnt = burst_cnt_ff - BURST_W'(1);
                end
            end
            default: begin
                nxt_burst_state = prbs_gen_pkg::BURST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            burst_state_ff <= prbs_gen_pkg::BURST_IDLE;
            burst_cnt_ff <= '0;
        end else if (clk_en) begin
            burst_state_ff <= nxt_burst_state;
            burst_cnt_ff <= nxt_burst_cnt;
        end
    end

    // ------------------------------------------------------------
    // Injection indicator
    // ------------------------------------------------------------
    localparam int IND_W = $clog2(INDICATOR_CYCLES + 1);
    logic [IND_W-1:0] ind_cnt_ff;

    assign error_injected = (ind_cnt_ff != '0); // see RL16

    // Each accepted command restarts the full hold time
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ind_cnt_ff <= '0;
        end else if (clk_en) begin
            if (burst_start) begin
                ind_cnt_ff <= IND_W'(INDICATOR_CYCLES); // see RL18
            end else if (ind_cnt_ff != '0) begin
                ind_cnt_ff <= ind_cnt_ff - IND_W'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // Data outputs
    // ------------------------------------------------------------
    logic data_ff;
    logic nxt_data;

    assign nxt_data = raw_bit ^ flip ^ cfg.negative_polarity; // see RL10
    assign data_out = data_ff;
    assign data_out_n = ~data_ff; // see RL20

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            data_ff <= 1'b0;
        end else if (clk_en) begin
            data_ff <= nxt_data;
        end
    end

    // ------------------------------------------------------------
    // Forwarded clock
    // ------------------------------------------------------------
    logic fwd_src;
    logic fwd_src_d_ff;
    logic fwd_tick;
    logic [3:0] fwd_div_log2;
    logic fwd_clk;

    assign fwd_src = cfg.channel_pair_high ? fwd_clk_pair_high : fwd_clk_pair_low; // see RL14
    // Divide by 4 or 2 means toggling every 2 or 1 rising source edges
    assign fwd_div_log2 = cfg.high_band ?
        4'($clog2(prbs_gen_pkg::FWD_DIV_HIGH_BAND) - 1) :
        4'($clog2(prbs_gen_pkg::FWD_DIV_LOW_BAND) - 1); // see RL13
    assign fwd_tick = fwd_src & ~fwd_src_d_ff;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fwd_src_d_ff <= 1'b0;
        end else if (clk_en) begin
            fwd_src_d_ff <= fwd_src;
        end
    end

    clk_divider #(
        .CNT_W(16)
    ) u_fwd_div (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .tick(fwd_tick),
        .div_log2(fwd_div_log2),
        .div_out(fwd_clk)
    );

    assign fwd_clk_out = fwd_clk;

    // ------------------------------------------------------------
    // Sync output
    // ------------------------------------------------------------
    logic marker_ok;
    logic sync_div_clk;
    logic sync_ff;
    logic nxt_sync;
    logic pattern_wrap;
    logic sync_tick;

    assign marker_ok = (cfg.sync_mode == prbs_gen_pkg::SYNC_MARKER) && !cfg.scope_tracking;
    assign marker_refused = (cfg.sync_mode == prbs_gen_pkg::SYNC_MARKER)
        && cfg.scope_tracking; // see RL17
    // Clock patterns repeat every 2 or 16 bits; PRBS at its seed
    assign pattern_wrap =
        (cfg.pattern == prbs_gen_pkg::PAT_PRBS) ? prbs_wrap :
        (cfg.pattern == prbs_gen_pkg::PAT_HALF) ? (phase_ff[0] == 1'b0) :
        (phase_ff == 4'h0); // see RL12
    // Divided mode counts either bit ticks or forwarded clock edges
    assign sync_tick = cfg.sync_src_forwarded ? fwd_tick : 1'b1; // see RL19

    clk_divider #(
        .CNT_W(16)
    ) u_sync_div (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .tick(sync_tick),
        .div_log2(cfg.sync_div_log2), // see RL19
        .div_out(sync_div_clk)
    );

    // Refused marker mode falls back to the divided clock
    assign nxt_sync = marker_ok ? pattern_wrap : sync_div_clk; // see RL11

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_ff <= 1'b0;
        end else if (clk_en) begin
            sync_ff <= nxt_sync;
        end
    end

    assign sync_out = sync_ff;
endmodule

// ===== verif/pulse_pattern_source_props.sv
// Port-level checks for the pattern source
`timescale 1ns/1ps
module pulse_pattern_source_props #(
    parameter int INDICATOR_CYCLES = 20,
    parameter int BURST_W = 5
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire prbs_gen_pkg::pattern_cfg_t cfg,
    input wire logic reseed,
    input wire logic insert_error,
    input wire logic fwd_clk_pair_low,
    input wire logic fwd_clk_pair_high,
    input wire logic data_out,
    input wire logic data_out_n,
    input wire logic sync_out,
    input wire logic fwd_clk_out,
    input wire logic error_injected,
    input wire logic marker_refused
);
    // ----------------------------------------
    // Helper counters
    // ----------------------------------------
    logic mk_ok;
    logic rs_ff;
    logic mk7;
    logic gap_ok_ff;
    logic [7:0] gap_ff;
    logic [4:0] half_ff;
    logic [4:0] six_ff;
    int ind_ff;
    assign mk_ok = cfg.pattern == prbs_gen_pkg::PAT_PRBS && !cfg.scope_tracking
        && cfg.sync_mode == prbs_gen_pkg::SYNC_MARKER && clk_en && !reseed && !rs_ff;
    assign mk7 = mk_ok && cfg.seq == prbs_gen_pkg::SEQ_7;
    // The gap, half and sixteenth counters saturate so a long steady pattern never wraps into a false start
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            gap_ok_ff <= 1'b0;
            rs_ff <= 1'b0;
            gap_ff <= 8'h00;
            half_ff <= 5'h00;
            six_ff <= 5'h00;
            ind_ff <= 0;
        end else begin
            // A reseed restarts the pattern, so the marker may double up once
            rs_ff <= reseed;
            gap_ok_ff <= mk7 && (sync_out || gap_ok_ff);
            gap_ff <= sync_out ? 8'h00 : gap_ff + {7'h00, gap_ff != 8'hff};
            half_ff <= (cfg.pattern == prbs_gen_pkg::PAT_HALF && clk_en && !reseed
                && !error_injected) ? half_ff + {4'h0, half_ff != 5'h1f} : 5'h00;
            six_ff <= (cfg.pattern == prbs_gen_pkg::PAT_SIXTEENTH && clk_en && !reseed
                && !error_injected) ? six_ff + {4'h0, six_ff != 5'h1f} : 5'h00;
            ind_ff <= error_injected ? ind_ff + 1 : 0;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    sequence s_pulse_seen;
        (mk_ok && sync_out) ##1 mk_ok;
    endsequence
    property p_comp;
        data_out_n == !data_out;
    endproperty
    property p_one_pulse;
        s_pulse_seen |-> !sync_out;
    endproperty
    property p_gap;
        (mk7 && gap_ok_ff && sync_out) |-> gap_ff == 8'h7e;
    endproperty
    property p_half;
        half_ff >= 5'h03 |-> data_out != $past(data_out);
    endproperty
    property p_six;
        (six_ff >= 5'h14 && $fell(data_out)) |-> $past(data_out, 8) && !$past(data_out, 9);
    endproperty
    property p_refuse;
        marker_refused == (cfg.sync_mode == prbs_gen_pkg::SYNC_MARKER && cfg.scope_tracking);
    endproperty
    property p_cause;
        $rose(error_injected) |-> $past(insert_error);
    endproperty
    property p_hold;
        $fell(error_injected) |-> ind_ff == INDICATOR_CYCLES;
    endproperty
    a_comp: assert property (p_comp)
        else $error("complement output not inverse");
    a_one_pulse: assert property (p_one_pulse)
        else $error("marker pulse longer than one cycle");
    a_gap: assert property (p_gap)
        else $error("marker interval not 127 bits");
    a_half: assert property (p_half)
        else $error("half rate pattern did not alternate");
    a_six: assert property (p_six)
        else $error("sixteenth rate run not eight bits");
    a_refuse: assert property (p_refuse)
        else $error("marker refusal flag wrong");
    a_cause: assert property (p_cause)
        else $error("indicator rose without a command");
    a_hold: assert property (p_hold)
        else $error("indicator held for wrong time");
endmodule

bind pulse_pattern_source pulse_pattern_source_props #(
    .INDICATOR_CYCLES(INDICATOR_CYCLES),
    .BURST_W(BURST_W)
) u_props (.sys_clk, .reset_n, .clk_en, .cfg, .reseed, .insert_error, .fwd_clk_pair_low,
    .fwd_clk_pair_high, .data_out, .data_out_n, .sync_out, .fwd_clk_out, .error_injected,
    .marker_refused);

// ===== verif/serial_sink_model.sv
// Receiving end model: locks to the 127-bit sequence and counts wrong bits
`timescale 1ns/1ps
module serial_sink_model (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic data_in,
    input wire logic data_in_n,
    input wire logic negative_polarity,
    input wire logic resync,
    output int err_cnt,
    output int pair_err
);
    // ----------------------------------------
    // Free-running local copy after lock
    // ----------------------------------------
    logic [6:0] hist_ff;
    int lock_cnt;
    logic rx_bit;
    logic exp_bit;
    assign rx_bit = data_in ^ negative_polarity;
    assign exp_bit = hist_ff[5] ^ hist_ff[6];
    // Local copy runs free, so each flipped line bit counts once, not three times
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            hist_ff <= 7'h00;
            lock_cnt <= 0;
            err_cnt <= 0;
            pair_err <= 0;
        end else begin
            if (data_in_n !== !data_in) begin
                pair_err <= pair_err + 1;
            end
            if (resync) begin
                lock_cnt <= 0;
                err_cnt <= 0;
            end else if (lock_cnt < 7) begin
                hist_ff <= {hist_ff[5:0], rx_bit};
                lock_cnt <= lock_cnt + 1;
            end else begin
                hist_ff <= {hist_ff[5:0], exp_bit};
                err_cnt <= err_cnt + int'(rx_bit !== exp_bit);
            end
        end
    end
endmodule

// ===== verif/test_pulse_pattern_source.sv
// Self-checking bench for the pattern source
`timescale 1ns/1ps
module test_pulse_pattern_source;
    typedef struct {
        prbs_gen_pkg::pattern_sel_t pat;
        prbs_gen_pkg::seq_sel_t seq;
        logic neg;
        int per;
        int ones;
        int run1;
        int run0;
    } row_t;
    logic sys_clk, reset_n, clk_en, reseed, insert_error, rx_resync;
    logic fwd_clk_pair_low, fwd_clk_pair_high, ps, pf;
    logic data_out, data_out_n, sync_out, fwd_clk_out, error_injected, marker_refused;
    prbs_gen_pkg::pattern_cfg_t cfg;
    int rx_err, pair_err, err_count, checked, cyc, n1, r, mx1, mx0, bad, st, ft;
    logic q[$];
    row_t rows[6] = '{
        '{prbs_gen_pkg::PAT_HALF, prbs_gen_pkg::SEQ_7, 1'b0, 2, 1, 1, 1},
        '{prbs_gen_pkg::PAT_SIXTEENTH, prbs_gen_pkg::SEQ_7, 1'b1, 16, 8, 8, 8},
        '{prbs_gen_pkg::PAT_PRBS, prbs_gen_pkg::SEQ_7, 1'b0, 127, 64, 7, 6},
        '{prbs_gen_pkg::PAT_PRBS, prbs_gen_pkg::SEQ_7, 1'b1, 127, 64, 7, 6},
        '{prbs_gen_pkg::PAT_PRBS, prbs_gen_pkg::SEQ_9, 1'b0, 511, 256, 9, 8},
        '{prbs_gen_pkg::PAT_PRBS, prbs_gen_pkg::SEQ_15, 1'b0, 32767, 16384, 15, 14}
    };
    // ----------------------------------------
    // Design and receiving end
    // ----------------------------------------
    pulse_pattern_source #(.INDICATOR_CYCLES(20)) u_dut (.sys_clk, .reset_n, .clk_en, .cfg,
        .reseed, .insert_error, .fwd_clk_pair_low, .fwd_clk_pair_high, .data_out, .data_out_n,
        .sync_out, .fwd_clk_out, .error_injected, .marker_refused);
    serial_sink_model u_rx (.sys_clk, .reset_n, .data_in(data_out), .data_in_n(data_out_n),
        .negative_polarity(cfg.negative_polarity), .resync(rx_resync), .err_cnt(rx_err),
        .pair_err);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Ceiling sits above the 32767-bit row, the longest by far
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 90000) begin
            err_count++;
            tally_and_finish();
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic cmp_int(input string what, input int exp, input int got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic cmp_bit(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic restart();
        reseed <= 1'b1;
        step(1);
        reseed <= 1'b0;
        step(20);
        rx_resync <= 1'b1;
        step(1);
        rx_resync <= 1'b0;
        step(20);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        {reset_n, reseed, insert_error, rx_resync, fwd_clk_pair_low, fwd_clk_pair_high} = '0;
        clk_en = 1'b1;
        cfg = '0;
        {err_count, checked, cyc} = '0;
        step(1);
        #1;
        cmp_bit("reset data_out_n", 1'b1, data_out_n);
        cmp_bit("reset indicator", 1'b0, error_injected);
        step(4);
        reset_n <= 1'b1;
        cfg.sync_mode <= prbs_gen_pkg::SYNC_MARKER;
        foreach (rows[i]) begin
            step(1);
            cfg.pattern <= rows[i].pat;
            cfg.seq <= rows[i].seq;
            cfg.negative_polarity <= rows[i].neg;
            restart();
            q.delete();
            repeat (2 * rows[i].per) begin
                @(posedge sys_clk);
                #1;
                q.push_back(data_out ^ rows[i].neg);
            end
            {n1, bad, r, mx1, mx0} = '0;
            foreach (q[k]) begin
                if (k < rows[i].per) begin
                    n1 += int'(q[k] === 1'b1);
                    bad += int'(q[k] !== q[k + rows[i].per]);
                end
                r = (k > 0 && q[k] === q[k - 1]) ? r + 1 : 1;
                if (q[k] === 1'b1 && r > mx1) mx1 = r;
                if (q[k] === 1'b0 && r > mx0) mx0 = r;
            end
            cmp_int("period repeats", 0, bad);
            cmp_int("ones count", rows[i].ones, n1);
            cmp_int("longest ones", rows[i].run1, mx1);
            cmp_int("longest zeros", rows[i].run0, mx0);
            if (rows[i].per == 127) cmp_int("rx slips", 0, rx_err);
            $display("pattern row %0d done", i);
        end
        for (int b = 0; b < 2; b++) begin
            step(1);
            cfg.seq <= prbs_gen_pkg::SEQ_7;
            cfg.high_band <= b[0];
            restart();
            insert_error <= 1'b1;
            step(1);
            insert_error <= 1'b0;
            #1;
            cmp_bit("indicator raised", 1'b1, error_injected);
            step(3);
            insert_error <= 1'b1;
            step(1);
            insert_error <= 1'b0;
            step(40);
            cmp_int("flipped bits", b ? 20 : 8, rx_err);
            cmp_bit("indicator clear", 1'b0, error_injected);
            $display("burst in band %0d done", b);
        end
        step(1);
        cfg.sync_mode <= prbs_gen_pkg::SYNC_DIVIDED;
        for (int m = 0; m < 4; m++) begin
            step(1);
            cfg.high_band <= m[0];
            cfg.channel_pair_high <= m[1];
            cfg.sync_src_forwarded <= m[1];
            cfg.sync_div_log2 <= {2'h0, m[0], 1'b0};
            {st, ft} = '0;
            for (int k = 0; k < 80; k++) begin
                @(posedge sys_clk);
                fwd_clk_pair_low <= !m[1] && k[2];
                fwd_clk_pair_high <= m[1] && k[2];
                #1;
                if (k >= 16) begin
                    st += int'(sync_out !== ps);
                    ft += int'(fwd_clk_out !== pf);
                end
                ps = sync_out;
                pf = fwd_clk_out;
            end
            cmp_int("sync toggles", m[1] ? (m[0] ? 2 : 8) : (m[0] ? 16 : 64), st);
            cmp_int("fwd clock toggles", m[0] ? 4 : 8, ft);
            $display("clock outputs case %0d done", m);
        end
        step(1);
        cfg.sync_mode <= prbs_gen_pkg::SYNC_MARKER;
        cfg.scope_tracking <= 1'b1;
        step(1);
        #1;
        cmp_bit("marker refused", 1'b1, marker_refused);
        cmp_int("pair mismatches", 0, pair_err);
        $display("refusal done");
        tally_and_finish();
    end
endmodule
